// ### src/nfc_cfg.svh
/*
   Offsets, field positions, reset values and timing counts of the upstream
   failover control block. Assumes a 100 MHz clock and byte addressing on the
   register bus.
*/
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

// ==========================================================================
// register offsets (byte addresses)
`define NFC_OFS_STATUS 12'h228
`define NFC_OFS_CONTROL 12'h22C
`define NFC_OFS_WATCHDOG 12'h230
`define NFC_OFS_IRQ_MASK 12'h234

// ==========================================================================
// status fields
`define NFC_STS_MODE 0
`define NFC_STS_DONE 1
`define NFC_STS_START 2

// ==========================================================================
// control fields
`define NFC_CTL_MODE_SEL 0
`define NFC_CTL_PIN_EN 1
`define NFC_CTL_TIMER_EN 2
`define NFC_CTL_SWAP_BLOCK 3
`define NFC_CTL_UP_LD_BLOCK 4
`define NFC_CTL_BR_LD_BLOCK 5
`define NFC_CTL_UP_IGNORE 6
`define NFC_CTL_BR_IGNORE 7

// ==========================================================================
// values
`define NFC_MODE_NORMAL 1'b0
`define NFC_MODE_SWAPPED 1'b1
`define NFC_BOOT_SWAP_A 4'h5
`define NFC_BOOT_SWAP_B 4'h6
`define NFC_RST_FLAG 1'b0
`define NFC_RST_CTL 7'h00
`define NFC_RST_MASK 2'h0
`define NFC_RST_COUNT 32'h0000_0000

// ==========================================================================
// timing
`define NFC_CLK_PERIOD_NS 10
`define NFC_TICK_NS 1000
`define NFC_TICK_CYCLES ((`NFC_TICK_NS + `NFC_CLK_PERIOD_NS - 1) / `NFC_CLK_PERIOD_NS)

`endif

// ### src/nfc_ctrl.sv
/*
   Upstream failover control and status registers, swap sequencer and hot
   reset gating, reached over an Avalon-MM slave with waitrequest.
   Assumes the port swap datapath takes swapStart/swapTarget and answers with
   swapComplete on this clock, and that switchOpMode is stable at reset.
*/
// Local design decision: the Avalon-MM interface to the registers.
// Function
// - status bit 0 reads current port association, 0 normal, 1 swapped.
// - swap-done flag at status bit 1 sets on completion, write one clears.
// - swap-started flag at status bit 2 sets on start, write one clears.
// - writing a differing mode-select value starts a swap toward that mode.
// - mode-select reads current mode, or during a swap the pending select value set by a write, the pin or the timer.
// - mode-select starts at one when boot operating mode is 5 or 6.
// - with pin enable set, pin disagreeing with current mode starts a swap.
// - with timer enable set, watchdog expiry starts a swap.
// - control bit 3 blocks link-down hot resets caused by a swap.
// - control bit 4 blocks hot reset on upstream link down.
// - control bit 5 blocks hot reset on bridge link down.
// - control bit 6 ignores hot resets received on the upstream port.
// - control bit 7 ignores hot resets received on the bridge port.
// - watchdog drops once per microsecond, stops at zero, expires on one-to-zero.
`timescale 1ns/100ps
`include "nfc_cfg.svh"
module nfc_ctrl #(
   parameter int WD_WIDTH = 32,
   parameter int TICK_CYCLES = `NFC_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hotReset,
   input wire logic [3:0] switchOpMode,
   input wire logic swapRequestPin,
   input wire logic swapComplete,
   output logic swapStart,
   output logic swapTarget,
   output logic currentSwapMode,
   input wire logic upLinkDown,
   input wire logic bridgeLinkDown,
   input wire logic upHotResetRx,
   input wire logic bridgeHotResetRx,
   output logic upHotResetOut,
   output logic bridgeHotResetOut,
   input wire logic [11:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq
);

   // ==========================================================================
   // declarations
   nfc_pkg::nfc_state_t state;
   nfc_pkg::nfc_state_t next_state;
   logic ack;
   logic next_ack;
   logic [31:0] next_readdata;
   logic request;
   logic doWrite;
   logic ctlWrite;
   logic stsWrite;
   logic maskWrite;
   logic wdWrite;
   logic swapModeSelect;
   logic next_swapModeSelect;
   logic next_currentSwapMode;
   logic next_swapTarget;
   logic initDone;
   logic next_initDone;
   logic bootSel;
   logic modeRead;
   logic busy;
   logic [`NFC_CTL_BR_IGNORE:`NFC_CTL_PIN_EN] ctrlBits;
   logic [`NFC_CTL_BR_IGNORE:`NFC_CTL_PIN_EN] next_ctrlBits;
   logic swapDoneFlag;
   logic next_swapDoneFlag;
   logic swapStartedFlag;
   logic next_swapStartedFlag;
   logic [`NFC_STS_START:`NFC_STS_DONE] irqMask;
   logic [`NFC_STS_START:`NFC_STS_DONE] next_irqMask;
   logic next_irq;
   logic next_upHotResetOut;
   logic next_bridgeHotResetOut;
   logic pinSync;
   logic [WD_WIDTH-1:0] wdCount;
   logic [WD_WIDTH-1:0] wdMerged;
   logic wdExpire;

   function automatic logic [31:0] mergeBytes(input logic [31:0] oldValue,
      input logic [31:0] newValue, input logic [3:0] lanes);
      logic [31:0] merged;
      merged = oldValue;
      for (int i = 0; i < 4; i++)
      begin
         if (lanes[i])
         begin
            merged[i*8 +: 8] = newValue[i*8 +: 8];
         end
      end
      return merged;
   endfunction : mergeBytes

   // ==========================================================================
   // helpers
   nfc_sync #(.WIDTH(1)) u_pinSync
   (
      .clk(clk),
      .rst_n(rst_n),
      .pinIn(swapRequestPin), // high asks for swapped, low for normal
      .synced(pinSync)
   );

   nfc_watchdog #(.WIDTH(WD_WIDTH), .TICK_CYCLES(TICK_CYCLES)) u_watchdog
   (
      .clk(clk),
      .rst_n(rst_n),
      .load(wdWrite),
      .loadValue(wdMerged),
      .count(wdCount),
      .expire(wdExpire)
   );

   // ==========================================================================
   // bus slave: one wait cycle, then the access takes effect
   assign request = read | write;
   assign waitrequest = request & ~ack;
   assign doWrite = write & ack;
   assign ctlWrite = doWrite && address == `NFC_OFS_CONTROL && byteenable[0];
   assign stsWrite = doWrite && address == `NFC_OFS_STATUS && byteenable[0];
   assign maskWrite = doWrite && address == `NFC_OFS_IRQ_MASK && byteenable[0];
   assign wdWrite = doWrite && address == `NFC_OFS_WATCHDOG && byteenable != 4'h0;
   assign wdMerged = WD_WIDTH'(mergeBytes(32'(wdCount), writedata, byteenable));
   assign busy = (state != nfc_pkg::NFC_IDLE);
   assign modeRead = busy ? swapModeSelect : currentSwapMode;
   assign bootSel = (switchOpMode == `NFC_BOOT_SWAP_A) || (switchOpMode == `NFC_BOOT_SWAP_B);
   assign swapStart = (state == nfc_pkg::NFC_START);

   always_comb
   begin
      next_ack = request & ~ack;
      next_readdata = readdata;
      if (request && !ack)
      begin
         next_readdata = 32'h0000_0000;
         case (address)
            `NFC_OFS_STATUS:
            begin
               next_readdata[`NFC_STS_MODE] = currentSwapMode;
               next_readdata[`NFC_STS_DONE] = swapDoneFlag;
               next_readdata[`NFC_STS_START] = swapStartedFlag;
            end
            `NFC_OFS_CONTROL:
            begin
               next_readdata[`NFC_CTL_MODE_SEL] = modeRead;
               next_readdata[`NFC_CTL_BR_IGNORE:`NFC_CTL_PIN_EN] = ctrlBits;
            end
            `NFC_OFS_WATCHDOG:
            begin
               next_readdata = 32'(wdCount);
            end
            `NFC_OFS_IRQ_MASK:
            begin
               next_readdata[`NFC_STS_START:`NFC_STS_DONE] = irqMask;
            end
            default:
            begin
               next_readdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ack <= 1'b0;
         readdata <= 32'h0000_0000;
      end
      else
      begin
         ack <= next_ack;
         readdata <= next_readdata;
      end
   end

   // ==========================================================================
   // mode select and swap sequencer
   always_comb
   begin
      next_state = state;
      next_currentSwapMode = currentSwapMode;
      next_swapModeSelect = swapModeSelect;
      next_swapTarget = swapTarget;
      next_ctrlBits = ctrlBits;
      next_initDone = 1'b1;
      if (!initDone)
      begin
         // strap caught on the first clock after release, not under reset
         next_currentSwapMode = bootSel;
         next_swapModeSelect = bootSel;
      end
      else
      begin
         // a write during a swap is simply queued behind it
         if (ctlWrite)
         begin
            next_ctrlBits = writedata[`NFC_CTL_BR_IGNORE:`NFC_CTL_PIN_EN];
            next_swapModeSelect = writedata[`NFC_CTL_MODE_SEL];
         end
         else if (!busy && ctrlBits[`NFC_CTL_PIN_EN] && pinSync != currentSwapMode)
         begin
            next_swapModeSelect = pinSync;
         end
         else if (ctrlBits[`NFC_CTL_TIMER_EN] && wdExpire)
         begin
            next_swapModeSelect = ~currentSwapMode;
         end
         case (state)
            nfc_pkg::NFC_IDLE:
            begin
               if (swapModeSelect != currentSwapMode)
               begin
                  next_state = nfc_pkg::NFC_START;
                  next_swapTarget = swapModeSelect;
               end
            end
            nfc_pkg::NFC_START:
            begin
               next_state = nfc_pkg::NFC_WAIT;
            end
            nfc_pkg::NFC_WAIT:
            begin
               if (swapComplete)
               begin
                  next_state = nfc_pkg::NFC_IDLE;
                  next_currentSwapMode = swapTarget;
               end
            end
            default:
            begin
               next_state = nfc_pkg::NFC_IDLE;
            end
         endcase
      end
   end

   // sticky state: untouched by hotReset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= nfc_pkg::NFC_IDLE;
         currentSwapMode <= `NFC_MODE_NORMAL;
         swapModeSelect <= `NFC_MODE_NORMAL;
         swapTarget <= `NFC_MODE_NORMAL;
         ctrlBits <= `NFC_RST_CTL;
         initDone <= 1'b0;
      end
      else
      begin
         state <= next_state;
         currentSwapMode <= next_currentSwapMode;
         swapModeSelect <= next_swapModeSelect;
         swapTarget <= next_swapTarget;
         ctrlBits <= next_ctrlBits;
         initDone <= next_initDone;
      end
   end

   // ==========================================================================
   // status flags, mask and interrupt; a flag set beats a same-cycle clear
   always_comb
   begin
      next_swapStartedFlag = (swapStartedFlag & ~(stsWrite & writedata[`NFC_STS_START]))
         | swapStart;
      next_swapDoneFlag = (swapDoneFlag & ~(stsWrite & writedata[`NFC_STS_DONE]))
         | (state == nfc_pkg::NFC_WAIT && swapComplete);
      next_irqMask = irqMask;
      if (hotReset)
      begin
         next_irqMask = `NFC_RST_MASK; // non-sticky
      end
      else if (maskWrite)
      begin
         next_irqMask = writedata[`NFC_STS_START:`NFC_STS_DONE];
      end
      next_irq = |({swapStartedFlag, swapDoneFlag} & irqMask);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         swapStartedFlag <= `NFC_RST_FLAG;
         swapDoneFlag <= `NFC_RST_FLAG;
         irqMask <= `NFC_RST_MASK;
         irq <= 1'b0;
      end
      else
      begin
         swapStartedFlag <= next_swapStartedFlag;
         swapDoneFlag <= next_swapDoneFlag;
         irqMask <= next_irqMask;
         irq <= next_irq;
      end
   end

   // ==========================================================================
   // hot reset gating
   always_comb
   begin
      next_upHotResetOut = (upLinkDown && !ctrlBits[`NFC_CTL_UP_LD_BLOCK]
         && !(busy && ctrlBits[`NFC_CTL_SWAP_BLOCK]))
         || (upHotResetRx && !ctrlBits[`NFC_CTL_UP_IGNORE]);
      next_bridgeHotResetOut = (bridgeLinkDown && !ctrlBits[`NFC_CTL_BR_LD_BLOCK]
         && !(busy && ctrlBits[`NFC_CTL_SWAP_BLOCK]))
         || (bridgeHotResetRx && !ctrlBits[`NFC_CTL_BR_IGNORE]);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         upHotResetOut <= 1'b0;
         bridgeHotResetOut <= 1'b0;
      end
      else
      begin
         upHotResetOut <= next_upHotResetOut;
         bridgeHotResetOut <= next_bridgeHotResetOut;
      end
   end

   // ==========================================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_swapFinish;
      state == nfc_pkg::NFC_WAIT && swapComplete;
   endsequence

   sequence s_modeWrite;
      ctlWrite && !busy && initDone && writedata[`NFC_CTL_MODE_SEL] != currentSwapMode;
   endsequence

   a_mode_follows: assert property (s_swapFinish |=> currentSwapMode == $past(swapTarget))
      else $error("mode did not take the swap target");
   a_done_flag: assert property (s_swapFinish |=> swapDoneFlag ##1 swapDoneFlag || stsWrite)
      else $error("done flag not set on completion");
   a_start_flag: assert property (swapStart |=> swapStartedFlag)
      else $error("started flag not set on swap start");
   a_write_swap: assert property (s_modeWrite |-> ##2 swapStart)
      else $error("mode write did not start a swap");
   a_read_mode: assert property ((request && !ack && address == `NFC_OFS_CONTROL)
      |=> readdata[`NFC_CTL_MODE_SEL] == $past(busy ? swapModeSelect : currentSwapMode))
      else $error("mode select read back wrong");
   a_boot_mode: assert property ($rose(initDone) |-> currentSwapMode == $past(bootSel))
      else $error("initial mode not taken from boot mode");
   a_pin_swap: assert property ((initDone && !busy && !ctlWrite && ctrlBits[`NFC_CTL_PIN_EN]
      && pinSync != currentSwapMode) |-> ##[1:2] swapStart)
      else $error("pin mismatch did not start a swap");
   a_timer_swap: assert property ((initDone && !busy && !ctlWrite && wdExpire
      && ctrlBits[`NFC_CTL_TIMER_EN] && !ctrlBits[`NFC_CTL_PIN_EN]) |-> ##[1:2] swapStart)
      else $error("watchdog expiry did not start a swap");
   a_swap_block: assert property ((busy && ctrlBits[`NFC_CTL_SWAP_BLOCK] && !upHotResetRx
      && !bridgeHotResetRx) |=> !upHotResetOut && !bridgeHotResetOut)
      else $error("hot reset raised during a blocked swap");
   a_up_ld_block: assert property ((ctrlBits[`NFC_CTL_UP_LD_BLOCK] && !upHotResetRx)
      |=> !upHotResetOut)
      else $error("upstream link down reset not blocked");
   a_br_ld_block: assert property ((ctrlBits[`NFC_CTL_BR_LD_BLOCK] && !bridgeHotResetRx)
      |=> !bridgeHotResetOut)
      else $error("bridge link down reset not blocked");
   a_up_ignore: assert property ((ctrlBits[`NFC_CTL_UP_IGNORE] && !upLinkDown)
      |=> !upHotResetOut)
      else $error("upstream hot reset not ignored");
   a_br_ignore: assert property ((ctrlBits[`NFC_CTL_BR_IGNORE] && !bridgeLinkDown)
      |=> !bridgeHotResetOut)
      else $error("bridge hot reset not ignored");
   a_sticky_keep: assert property ((hotReset && !ctlWrite && initDone)
      |=> ctrlBits == $past(ctrlBits) && irqMask == `NFC_RST_MASK)
      else $error("hot reset disturbed sticky control");

endmodule : nfc_ctrl

// ### src/nfc_pkg.sv
/*
   Types of the upstream failover control block.
   Assumes nothing of its surroundings.
*/
package nfc_pkg;

   // ==========================================================================
   // swap sequencer states, gray along idle -> start -> wait
   typedef enum logic [1:0]
   {
      NFC_IDLE = 2'b00,
      NFC_START = 2'b01,
      NFC_WAIT = 2'b11
   } nfc_state_t;

endpackage : nfc_pkg

// ### src/nfc_sync.sv
/*
   Two flip-flop synchroniser for level inputs.
   Assumes the inputs are levels that stay put for several clocks.
*/
`timescale 1ns/100ps
module nfc_sync #(parameter int WIDTH = 1)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta <= '0;
         synced <= '0;
      end
      else
      begin
         meta <= pinIn;
         synced <= meta;
      end
   end

endmodule : nfc_sync

// ### src/nfc_watchdog.sv
/*
   Failover watchdog: a count that drops by one every microsecond, stops at
   zero and pulses expire on the step from one to zero.
   Assumes load comes from the register bus on the same clock.
*/
`timescale 1ns/100ps
`include "nfc_cfg.svh"
module nfc_watchdog #(
   parameter int WIDTH = 32,
   parameter int TICK_CYCLES = `NFC_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] loadValue,
   output logic [WIDTH-1:0] count,
   output logic expire
);

   localparam int DW = $clog2(TICK_CYCLES + 1);

   logic [DW-1:0] divCount;
   logic [DW-1:0] next_divCount;
   logic [WIDTH-1:0] next_count;
   logic next_expire;
   logic tick;

   assign tick = (divCount == DW'(TICK_CYCLES - 1));

   // ==========================================================================
   // microsecond divider and count
   always_comb
   begin
      next_divCount = tick ? '0 : DW'(divCount + 1'b1);
      next_count = count;
      next_expire = 1'b0;
      if (load)
      begin
         next_count = loadValue;
      end
      else if (tick && count != '0)
      begin
         next_count = count - WIDTH'(1);
         next_expire = (count == WIDTH'(1));
      end
   end

   // sticky: only the fundamental reset clears the count
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         divCount <= '0;
         count <= WIDTH'(`NFC_RST_COUNT);
         expire <= 1'b0;
      end
      else
      begin
         divCount <= next_divCount;
         count <= next_count;
         expire <= next_expire;
      end
   end

   a_count_stops: assert property (@(posedge clk) disable iff (!rst_n)
      (count == '0 && !load) |=> count == '0)
      else $error("watchdog count left zero without a load");
   a_expire_step: assert property (@(posedge clk) disable iff (!rst_n)
      expire |-> count == '0 && $past(count) == WIDTH'(1))
      else $error("expire without a one to zero step");

endmodule : nfc_watchdog

// ### tb/test_nfc_ctrl.sv
/*
   Self-checking bench for the upstream failover control block: boot mode,
   software, pin and timer swaps, status flags, irq, hot reset gating.
   Assumes nfc_ctrl answers Avalon-MM with one wait cycle and a short tick.
*/
`timescale 1ns/100ps
`include "nfc_cfg.svh"
module test_nfc_ctrl;
   // short tick keeps the watchdog run brief
   localparam int TICK = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hotReset = 1'b0;
   logic [3:0] switchOpMode = 4'h0;
   logic swapRequestPin = 1'b0;
   logic swapComplete = 1'b0;
   // {bridge rx, up rx, bridge link down, up link down}
   logic [3:0] cause = 4'h0;
   logic [11:0] address = 12'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hF;
   logic swapStart;
   logic swapTarget;
   logic currentSwapMode;
   logic upHotResetOut;
   logic bridgeHotResetOut;
   logic [31:0] readdata;
   logic waitrequest;
   logic irq;
   int n_errors = 0;
   int compares = 0;
   int waited;

   always #5 clk = ~clk;

   nfc_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .rst_n(rst_n), .hotReset(hotReset),
      .switchOpMode(switchOpMode), .swapRequestPin(swapRequestPin),
      .swapComplete(swapComplete), .swapStart(swapStart), .swapTarget(swapTarget),
      .currentSwapMode(currentSwapMode), .upLinkDown(cause[0]),
      .bridgeLinkDown(cause[1]), .upHotResetRx(cause[2]), .bridgeHotResetRx(cause[3]),
      .upHotResetOut(upHotResetOut), .bridgeHotResetOut(bridgeHotResetOut),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .irq(irq));

   // ==========================================================================
   // helpers
   task automatic tally_and_finish;
      $display("mismatches %0d of %0d compares", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] data,
      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      address <= addr;
      writedata <= data;
      write <= wr;
      read <= ~wr;
      // no wait limit of its own: only the run watchdog ends a hung access
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // one wait cycle: answer seen at the second edge of the request
      check(32'(n), 32'h0000_0002, "bus answer edges");
   endtask : bus

   task automatic bus_wr(input logic [11:0] addr, input logic [31:0] data);
      logic [31:0] dummy;
      bus(1'b1, addr, data, dummy);
   endtask : bus_wr

   task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input string what);
      logic [31:0] got;
      bus(1'b0, addr, 32'h0000_0000, got);
      check(got, exp, what);
   endtask : rdchk

   task automatic do_reset(input logic [3:0] m);
      @(posedge clk);
      rst_n <= 1'b0;
      switchOpMode <= m;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset

   task automatic wait_start(input int limit, input logic expTarget, output int n);
      n = 0;
      while (swapStart !== 1'b1 && n < limit)
      begin
         @(negedge clk);
         n++;
      end
      check(swapStart, 1'b1, "swap start pulse");
      check(swapTarget, expTarget, "swap target");
   endtask : wait_start

   task automatic complete_swap;
      @(posedge clk);
      swapComplete <= 1'b1;
      @(posedge clk);
      swapComplete <= 1'b0;
      @(negedge clk);
   endtask : complete_swap

   task automatic hot_pulse(input int idx, input logic [1:0] exp);
      @(posedge clk);
      cause[idx] <= 1'b1;
      @(posedge clk);
      cause <= 4'h0;
      @(negedge clk);
      check({upHotResetOut, bridgeHotResetOut}, exp, "hot reset outputs");
   endtask : hot_pulse

   // ==========================================================================
   // watchdog: whole run is a few hundred cycles
   initial
   begin
      #200000;
      n_errors++;
      $display("[ERR] %0t run did not finish in time", $time);
      tally_and_finish();
   end

   // ==========================================================================
   // tests
   initial
   begin
      for (int m = 0; m < 8; m++)
      begin
         do_reset(m[3:0]);
         rdchk(`NFC_OFS_CONTROL, {31'h0, m == 5 || m == 6}, "boot select");
         rdchk(`NFC_OFS_STATUS, {31'h0, m == 5 || m == 6}, "boot status");
      end
      rdchk(12'h300, 32'h0000_0000, "unmapped read");
      // software swap toward 1 with swap-caused link-down resets blocked
      bus_wr(`NFC_OFS_CONTROL, 32'h0000_0009);
      wait_start(10, 1'b1, waited);
      rdchk(`NFC_OFS_CONTROL, 32'h0000_0009, "select during swap");
      rdchk(`NFC_OFS_STATUS, 32'h0000_0004, "started flag");
      hot_pulse(0, 2'b00);
      hot_pulse(1, 2'b00);
      complete_swap();
      check(currentSwapMode, 1'b1, "mode after swap");
      rdchk(`NFC_OFS_STATUS, 32'h0000_0007, "done flag");
      check(irq, 1'b0, "irq while masked");
      bus_wr(`NFC_OFS_IRQ_MASK, 32'h0000_0006);
      repeat (2) @(negedge clk);
      check(irq, 1'b1, "irq unmasked");
      bus_wr(`NFC_OFS_STATUS, 32'h0000_0006);
      repeat (2) @(negedge clk);
      check(irq, 1'b0, "irq after clear");
      rdchk(`NFC_OFS_STATUS, 32'h0000_0001, "flags cleared");
      // each block bit against its own cause, mode kept at 1
      for (int i = 0; i < 4; i++)
      begin
         bus_wr(`NFC_OFS_CONTROL, 32'h0000_0001);
         hot_pulse(i, (i % 2) ? 2'b01 : 2'b10);
         bus_wr(`NFC_OFS_CONTROL, 32'h0000_0001 | (32'h0000_0010 << i));
         hot_pulse(i, 2'b00);
      end
      // pin trigger: agreeing pin does nothing, disagreeing pin swaps
      @(posedge clk);
      swapRequestPin <= 1'b1;
      bus_wr(`NFC_OFS_CONTROL, 32'h0000_0003);
      repeat (6) @(negedge clk);
      rdchk(`NFC_OFS_STATUS, 32'h0000_0001, "no swap while pin agrees");
      @(posedge clk);
      swapRequestPin <= 1'b0;
      wait_start(10, 1'b0, waited);
      complete_swap();
      rdchk(`NFC_OFS_CONTROL, 32'h0000_0002, "select follows mode");
      bus_wr(`NFC_OFS_CONTROL, 32'h0000_0000);
      // timer trigger after three ticks
      bus_wr(`NFC_OFS_CONTROL, 32'h0000_0004);
      bus_wr(`NFC_OFS_WATCHDOG, 32'h0000_0003);
      wait_start(3 * TICK + 10, 1'b1, waited);
      check(waited >= 2 * TICK, 1'b1, "expiry too early");
      rdchk(`NFC_OFS_WATCHDOG, 32'h0000_0000, "count stops at zero");
      complete_swap();
      check(currentSwapMode, 1'b1, "mode after timer swap");
      // hot reset keeps sticky fields, clears only the mask
      bus_wr(`NFC_OFS_CONTROL, 32'h0000_00F5);
      @(posedge clk);
      hotReset <= 1'b1;
      @(posedge clk);
      hotReset <= 1'b0;
      rdchk(`NFC_OFS_CONTROL, 32'h0000_00F5, "control after hot reset");
      rdchk(`NFC_OFS_STATUS, 32'h0000_0007, "flags after hot reset");
      rdchk(`NFC_OFS_IRQ_MASK, 32'h0000_0000, "mask after hot reset");
      tally_and_finish();
   end
endmodule : test_nfc_ctrl
